// ### rtl/tcir_defines.svh
// Purpose: Offsets, fields, reset values and timing for the recal/irq register group
// Assumes: 250 MHz clk_sys
// Notes: Header only, no logic
`ifndef TCIR_DEFINES_SVH
`define TCIR_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define TCIR_ADDR_GROUP_TIMING 8'h24
`define TCIR_ADDR_AUTO_RECAL 8'h25
`define TCIR_ADDR_MANUAL_TRIG 8'h26
`define TCIR_ADDR_TOUCH_IRQ 8'h27
`define TCIR_ADDR_GPIN_IRQ 8'h28
`define TCIR_ADDR_GROUP_TRIG 8'h46

// ****************************************
// Reset values and fields
// ****************************************
`define TCIR_RST_GROUP_TIMING 8'hD4
`define TCIR_RST_AUTO_RECAL 8'hFF
`define TCIR_RST_MANUAL_TRIG 8'h00
`define TCIR_RST_TOUCH_IRQ 8'hFF
`define TCIR_RST_GPIN_IRQ 8'h00
`define TCIR_RST_GROUP_TRIG 8'h00
`define TCIR_PRESS_LIMIT_MSB 7
`define TCIR_PRESS_LIMIT_LSB 4
`define TCIR_SLIDE_RPT_MSB 3
`define TCIR_SLIDE_RPT_LSB 0
`define TCIR_GROUP_BIT 7

// ****************************************
// Timing
// ****************************************
`define TCIR_CLK_PERIOD_NS 4
`define TCIR_MS_IN_NS 1000000
`define TCIR_CYC_PER_MS (`TCIR_MS_IN_NS / `TCIR_CLK_PERIOD_NS)
`define TCIR_RECAL_MAX_MS 600
`define TCIR_ANALOG_MS 100
`define TCIR_DIGITAL_MS (`TCIR_RECAL_MAX_MS - `TCIR_ANALOG_MS)
`define TCIR_REPEAT_STEP_MS 35

`endif

// ### rtl/tcir_pkg.sv
// Purpose: Shared types of the recal/irq register group
// Assumes: Nothing
// Notes: Constants live in tcir_defines.svh
package tcir_pkg;
    typedef enum logic [2:0] {
        CAL_IDLE = 3'h1,
        CAL_ANALOG = 3'h2,
        CAL_DIGITAL = 3'h4
    } tcir_cal_state_t;
    typedef logic [13:0] tcir_sensor_mask_t;
endpackage

// ### rtl/tcir_timing_decode.sv
// Purpose: Decode of press limit and slide repeat nibbles
// Assumes: Codes are stable register fields
// Notes: Purely combinational
`timescale 1ns/10ps
`include "tcir_defines.svh"
module tcir_timing_decode (
    input wire logic [3:0] pressCode,
    input wire logic [3:0] slideCode,
    input wire logic [1:0] slideSpeed,
    output logic [13:0] pressLimitMs,
    output logic [9:0] slideRepeatMs
);
    import tcir_pkg::*;

    logic [4:0] steps;

    always_comb begin
        case (pressCode)
            4'h0: pressLimitMs = 14'd560;
            4'h1: pressLimitMs = 14'd840;
            4'h2: pressLimitMs = 14'd1120;
            4'h3: pressLimitMs = 14'd1400;
            4'h4: pressLimitMs = 14'd1680;
            4'h5: pressLimitMs = 14'd2240;
            4'h6: pressLimitMs = 14'd2800;
            4'h7: pressLimitMs = 14'd3360;
            4'h8: pressLimitMs = 14'd3920;
            4'h9: pressLimitMs = 14'd4480;
            4'hA: pressLimitMs = 14'd5600;
            4'hB: pressLimitMs = 14'd6720;
            4'hC: pressLimitMs = 14'd7840;
            4'hD: pressLimitMs = 14'd8906;
            4'hE: pressLimitMs = 14'd10080;
            default: pressLimitMs = 14'd11200;
        endcase
    end

    // Faster slides shorten the interval, never below one step
    always_comb begin
        steps = ({1'b0, slideCode} + 5'h01) >> slideSpeed;
        if (steps == 5'h00) begin
            steps = 5'h01;
        end
        slideRepeatMs = 10'(steps * `TCIR_REPEAT_STEP_MS);
    end
endmodule

// ### rtl/tcir_recal_engine.sv
// Purpose: Recalibration sequencer for fourteen sensors
// Assumes: msTick is a one-cycle pulse per millisecond
// Notes: One job at a time; requests are taken only in idle, so they must stay asserted
`timescale 1ns/10ps
`include "tcir_defines.svh"
module tcir_recal_engine (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic msTick,
    input wire tcir_pkg::tcir_sensor_mask_t reqMask,
    input wire tcir_pkg::tcir_sensor_mask_t touchRaw,
    output tcir_pkg::tcir_sensor_mask_t busyMask,
    output tcir_pkg::tcir_sensor_mask_t doneMask,
    output tcir_pkg::tcir_sensor_mask_t okMask
);
    import tcir_pkg::*;

    tcir_cal_state_t state_r, state_nxt;
    tcir_sensor_mask_t job_r, job_nxt, fail_r, fail_nxt;
    logic [9:0] cnt_r, cnt_nxt;

    // ****************************************
    // Sequencer
    // ****************************************
    always_comb begin
        state_nxt = state_r;
        job_nxt = job_r;
        cnt_nxt = cnt_r;
        fail_nxt = fail_r | (job_r & touchRaw);
        doneMask = '0;
        okMask = '0;
        case (state_r)
            CAL_IDLE: begin
                fail_nxt = '0;
                if (|reqMask) begin
                    job_nxt = reqMask;
                    cnt_nxt = '0;
                    state_nxt = CAL_ANALOG;
                end
            end
            CAL_ANALOG: begin
                if (msTick) begin
                    if (cnt_r == 10'(`TCIR_ANALOG_MS - 1)) begin
                        cnt_nxt = '0;
                        state_nxt = CAL_DIGITAL;
                    end else begin
                        cnt_nxt = cnt_r + 10'h001;
                    end
                end
            end
            CAL_DIGITAL: begin
                if (msTick) begin
                    if (cnt_r == 10'(`TCIR_DIGITAL_MS - 1)) begin
                        doneMask = job_r;
                        okMask = job_r & ~fail_nxt;
                        job_nxt = '0;
                        state_nxt = CAL_IDLE;
                    end else begin
                        cnt_nxt = cnt_r + 10'h001;
                    end
                end
            end
            default: begin
                job_nxt = '0;
                state_nxt = CAL_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_r <= CAL_IDLE;
            job_r <= '0;
            fail_r <= '0;
            cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            job_r <= job_nxt;
            fail_r <= fail_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign busyMask = job_r;

    // ****************************************
    // Checks
    // ****************************************
    sequence leaveAnalog;
        state_r == CAL_ANALOG ##1 state_r != CAL_ANALOG;
    endsequence
    property analogThenDigital;
        @(posedge clk_sys) disable iff (!resetn) leaveAnalog |-> state_r == CAL_DIGITAL;
    endproperty
    phaseOrder_a: assert property (analogThenDigital)
        else $error("digital phase did not follow analog phase");
    failExcluded_a: assert property (
        @(posedge clk_sys) disable iff (!resetn) (okMask & fail_r) == '0)
        else $error("touched sensor reported as calibrated");
endmodule

// ### rtl/tcir_regs.sv
// Purpose: Recalibration and alert register group of the touch controller
// Assumes: Register port strobes are synchronous to clk_sys
// Notes: Status bits arrive from the status block outside
// Function
// - Timing register at 24h resets to D4h
// - Low nibble sets slide repeat base interval
// - Press limit nibble decodes 560ms to 11200ms
// - Register 25h resets FFh, per-sensor auto enables
// - Bit 7 recalibrates all sampled grouped sensors together
// - Auto enable ignored for unsampled sensors
// - Register 26h triggers, self-clear on successful completion
// - Register 46h triggers grouped sensors individually
// - Group trigger holds until all grouped succeed
// - Analog update phase, then digital base capture
// - Calibrating sensors report no touch, base invalid
// - Touch during calibration invalidates that calibration
// - Register 27h resets FFh, touch alert enables
// - Bit 7 gates grouped gesture events to alert
// - Register 28h resets 00h, input alert enables
// - Input enable bit zero masks its alert
`timescale 1ns/10ps
`include "tcir_defines.svh"
module tcir_regs #(
    parameter int CYC_PER_MS = `TCIR_CYC_PER_MS
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData_r,
    input wire tcir_pkg::tcir_sensor_mask_t sampleEn,
    input wire tcir_pkg::tcir_sensor_mask_t autoRecalReq,
    input wire tcir_pkg::tcir_sensor_mask_t touchRaw,
    input wire logic [1:0] slideSpeed,
    input wire logic [6:0] touchStatus,
    input wire logic [3:0] groupEventStatus,
    input wire logic [7:0] gpinStatus,
    output tcir_pkg::tcir_sensor_mask_t touchReported_r,
    output tcir_pkg::tcir_sensor_mask_t baseValid_r,
    output tcir_pkg::tcir_sensor_mask_t calBusy_r,
    output logic [13:0] pressLimitMs_r,
    output logic [9:0] slideRepeatMs_r,
    output logic alert_r
);
    import tcir_pkg::*;

    logic [7:0] groupTiming_r, groupTiming_nxt;
    logic [7:0] autoRecalEn_r, autoRecalEn_nxt;
    logic [7:0] manualTrig_r, manualTrig_nxt;
    logic [7:0] touchIrqEn_r, touchIrqEn_nxt;
    logic [7:0] gpinIrqEn_r, gpinIrqEn_nxt;
    logic [6:0] groupTrig_r, groupTrig_nxt;
    logic [7:0] regRdData_nxt;
    logic [17:0] msCnt_r, msCnt_nxt;
    logic [13:0] pressMs_r, pressMs_nxt;
    logic forcePend_r, forcePend_nxt;
    logic msTick;
    logic groupTouched;
    logic groupAllOk;
    logic irqCause;
    logic [13:0] pressLimitMs;
    logic [9:0] slideRepeatMs;
    tcir_sensor_mask_t autoMask, reqMask, busyMask, doneMask, okMask;

    // ****************************************
    // Timing decode and recal engine
    // ****************************************
    tcir_timing_decode u_decode (
        .pressCode(groupTiming_r[`TCIR_PRESS_LIMIT_MSB:`TCIR_PRESS_LIMIT_LSB]),
        .slideCode(groupTiming_r[`TCIR_SLIDE_RPT_MSB:`TCIR_SLIDE_RPT_LSB]),
        .slideSpeed(slideSpeed),
        .pressLimitMs(pressLimitMs),
        .slideRepeatMs(slideRepeatMs)
    );

    tcir_recal_engine u_engine (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .msTick(msTick),
        .reqMask(reqMask),
        .touchRaw(touchRaw),
        .busyMask(busyMask),
        .doneMask(doneMask),
        .okMask(okMask)
    );

    // ****************************************
    // Request gathering
    // ****************************************
    assign msTick = (msCnt_r == 18'(CYC_PER_MS - 1));
    assign groupTouched = |touchRaw[13:7];
    assign groupAllOk = &okMask[13:7];

    // Group bit makes grouped sensors move as one block
    always_comb begin
        autoMask[6:0] = autoRecalReq[6:0] & autoRecalEn_r[6:0] & sampleEn[6:0];
        autoMask[13:7] = '0;
        if (autoRecalEn_r[`TCIR_GROUP_BIT] && |(autoRecalReq[13:7] & sampleEn[13:7])) begin
            autoMask[13:7] = sampleEn[13:7];
        end
        reqMask = autoMask;
        reqMask[6:0] = reqMask[6:0] | manualTrig_r[6:0];
        reqMask[13:7] = reqMask[13:7] | groupTrig_r;
        if (manualTrig_r[`TCIR_GROUP_BIT] || forcePend_r) begin
            reqMask[13:7] = 7'h7F;
        end
    end

    // ****************************************
    // Millisecond base and group press limit
    // ****************************************
    // Counter stops at the limit and clears during a group recal, so a held press forces one recal per limit
    always_comb begin
        msCnt_nxt = msTick ? '0 : msCnt_r + 18'h00001;
        pressMs_nxt = pressMs_r;
        forcePend_nxt = forcePend_r;
        if (!groupTouched || |busyMask[13:7]) begin
            pressMs_nxt = '0;
        end else if (msTick && pressMs_r < pressLimitMs) begin
            pressMs_nxt = pressMs_r + 14'h0001;
        end
        if (|doneMask[13:7]) begin
            forcePend_nxt = 1'b0;
        end
        if (pressMs_nxt == pressLimitMs && pressMs_r != pressLimitMs) begin
            forcePend_nxt = 1'b1;
        end
    end

    // ****************************************
    // Register writes
    // ****************************************
    // A write of one wins over a same-cycle completion clear
    always_comb begin
        groupTiming_nxt = groupTiming_r;
        autoRecalEn_nxt = autoRecalEn_r;
        touchIrqEn_nxt = touchIrqEn_r;
        gpinIrqEn_nxt = gpinIrqEn_r;
        manualTrig_nxt[6:0] = manualTrig_r[6:0] & ~okMask[6:0];
        manualTrig_nxt[7] = manualTrig_r[7] & ~groupAllOk;
        groupTrig_nxt = groupTrig_r & ~okMask[13:7];
        if (regWrEn) begin
            case (regAddr)
                `TCIR_ADDR_GROUP_TIMING: groupTiming_nxt = regWrData;
                `TCIR_ADDR_AUTO_RECAL: autoRecalEn_nxt = regWrData;
                `TCIR_ADDR_MANUAL_TRIG: manualTrig_nxt = manualTrig_nxt | regWrData;
                `TCIR_ADDR_TOUCH_IRQ: touchIrqEn_nxt = regWrData;
                `TCIR_ADDR_GPIN_IRQ: gpinIrqEn_nxt = regWrData;
                `TCIR_ADDR_GROUP_TRIG: groupTrig_nxt = groupTrig_nxt | regWrData[6:0];
                default: groupTiming_nxt = groupTiming_r;
            endcase
        end
    end

    // ****************************************
    // Register reads
    // ****************************************
    always_comb begin
        regRdData_nxt = regRdData_r;
        if (regRdEn) begin
            case (regAddr)
                `TCIR_ADDR_GROUP_TIMING: regRdData_nxt = groupTiming_r;
                `TCIR_ADDR_AUTO_RECAL: regRdData_nxt = autoRecalEn_r;
                `TCIR_ADDR_MANUAL_TRIG: regRdData_nxt = manualTrig_r;
                `TCIR_ADDR_TOUCH_IRQ: regRdData_nxt = touchIrqEn_r;
                `TCIR_ADDR_GPIN_IRQ: regRdData_nxt = gpinIrqEn_r;
                `TCIR_ADDR_GROUP_TRIG: regRdData_nxt = {1'b0, groupTrig_r};
                default: regRdData_nxt = 8'h00;
            endcase
        end
    end

    // ****************************************
    // Alert
    // ****************************************
    always_comb begin
        irqCause = |(touchStatus & touchIrqEn_r[6:0]);
        irqCause = irqCause | (touchIrqEn_r[`TCIR_GROUP_BIT] & |groupEventStatus);
        irqCause = irqCause | |(gpinStatus & gpinIrqEn_r);
    end

    // ****************************************
    // State registers
    // ****************************************
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            groupTiming_r <= `TCIR_RST_GROUP_TIMING;
            autoRecalEn_r <= `TCIR_RST_AUTO_RECAL;
            manualTrig_r <= `TCIR_RST_MANUAL_TRIG;
            touchIrqEn_r <= `TCIR_RST_TOUCH_IRQ;
            gpinIrqEn_r <= `TCIR_RST_GPIN_IRQ;
            groupTrig_r <= 7'(`TCIR_RST_GROUP_TRIG);
            regRdData_r <= 8'h00;
            msCnt_r <= '0;
            pressMs_r <= '0;
            forcePend_r <= 1'b0;
            touchReported_r <= '0;
            baseValid_r <= '0;
            calBusy_r <= '0;
            pressLimitMs_r <= '0;
            slideRepeatMs_r <= '0;
            alert_r <= 1'b0;
        end else begin
            groupTiming_r <= groupTiming_nxt;
            autoRecalEn_r <= autoRecalEn_nxt;
            manualTrig_r <= manualTrig_nxt;
            touchIrqEn_r <= touchIrqEn_nxt;
            gpinIrqEn_r <= gpinIrqEn_nxt;
            groupTrig_r <= groupTrig_nxt;
            regRdData_r <= regRdData_nxt;
            msCnt_r <= msCnt_nxt;
            pressMs_r <= pressMs_nxt;
            forcePend_r <= forcePend_nxt;
            touchReported_r <= touchRaw & ~busyMask;
            baseValid_r <= ~busyMask;
            calBusy_r <= busyMask;
            pressLimitMs_r <= pressLimitMs;
            slideRepeatMs_r <= slideRepeatMs;
            alert_r <= irqCause;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    alertCause_a: assert property (1'b1 |=> alert_r == $past(irqCause))
        else $error("alert does not follow enabled status");
    gpinMask_a: assert property (
        (touchIrqEn_r == 8'h00 && (gpinStatus & gpinIrqEn_r) == 8'h00) |=> !alert_r)
        else $error("alert raised by masked input");
    touchMute_a: assert property (
        1'b1 |=> (touchReported_r & $past(busyMask)) == '0)
        else $error("touch reported during recalibration");
    trigHold_a: assert property (
        1'b1 |=> (($past(manualTrig_r[6:0]) & ~$past(okMask[6:0])) & ~manualTrig_r[6:0]) == 7'h00)
        else $error("trigger cleared without success");
    groupHold_a: assert property (
        (manualTrig_r[7] && !groupAllOk) |=> manualTrig_r[7])
        else $error("group trigger cleared early");
    trigClear_a: assert property (
        (okMask[13:7] != 7'h00 && !regWrEn) |=> (groupTrig_r & $past(okMask[13:7])) == 7'h00)
        else $error("grouped trigger not cleared on success");
    autoGate_a: assert property ((autoMask & ~sampleEn) == '0)
        else $error("auto recal on unsampled sensor");
    readBack_a: assert property (
        (regRdEn && regAddr == `TCIR_ADDR_GROUP_TIMING) |=> regRdData_r == $past(groupTiming_r))
        else $error("timing register readback mismatch");
endmodule

// ### testbench/tcir_host_model.sv
// Purpose: Host side of the register port, strobe reads and writes
// Assumes: Caller enters tasks at any time, drives land on rising edges
// Notes: Address and data show inverted junk when idle
`timescale 1ns/10ps
module tcir_host_model (
    input wire logic clk_sys,
    output logic regWrEn,
    output logic regRdEn,
    output logic [7:0] regAddr,
    output logic [7:0] regWrData,
    input wire logic [7:0] regRdData_r,
    input wire logic alert_r
);
    initial begin
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk_sys);
        regWrEn <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRdEn <= 1'b0;
        regAddr <= ~a;
        #1;
        d = regRdData_r;
    endtask

    // Touch during a job leaves the trigger set, so ask again
    task automatic pollRetry(input logic [7:0] a, input logic [7:0] m, output logic stuck);
        logic [7:0] d;
        rd(a, d);
        stuck = |(d & m);
        if (stuck) begin
            wr(a, m);
        end
    endtask
endmodule

// ### testbench/tcir_regs_test.sv
// Purpose: Self-checking bench of the recal and alert register group
// Assumes: CYC_PER_MS shrunk to 4, so one recal job is 2400 cycles
// Notes: Row table covers enables and alert, hand tests cover recal
`timescale 1ns/10ps
`include "tcir_defines.svh"
module tcir_regs_test;
    import tcir_pkg::*;
    localparam int CYC = 4;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] expRd;
        logic [6:0] tStat;
        logic [3:0] gEv;
        logic [7:0] gp;
        logic expAlert;
    } tcir_row_t;
    localparam tcir_row_t ROWS [13] = '{
        '{8'h27, 8'hFF, 8'hFF, 7'h01, 4'h0, 8'h00, 1'b1},
        '{8'h27, 8'h7F, 8'h7F, 7'h00, 4'h1, 8'h00, 1'b0},
        '{8'h27, 8'h80, 8'h80, 7'h7F, 4'h0, 8'h00, 1'b0},
        '{8'h27, 8'h80, 8'h80, 7'h00, 4'h2, 8'h00, 1'b1},
        '{8'h27, 8'h80, 8'h80, 7'h00, 4'h4, 8'h00, 1'b1},
        '{8'h27, 8'h80, 8'h80, 7'h00, 4'h8, 8'h00, 1'b1},
        '{8'h28, 8'h00, 8'h00, 7'h00, 4'h0, 8'hFF, 1'b0},
        '{8'h28, 8'h01, 8'h01, 7'h00, 4'h0, 8'h01, 1'b1},
        '{8'h28, 8'hFE, 8'hFE, 7'h00, 4'h0, 8'h01, 1'b0},
        '{8'h28, 8'h80, 8'h80, 7'h00, 4'h0, 8'h80, 1'b1},
        '{8'h30, 8'hFF, 8'h00, 7'h00, 4'h0, 8'h00, 1'b0},
        '{8'h24, 8'h35, 8'h35, 7'h00, 4'h0, 8'h00, 1'b0},
        '{8'h25, 8'h7F, 8'h7F, 7'h00, 4'h0, 8'h00, 1'b0}};
    localparam logic [13:0] PRESS_MS [16] = '{14'h0230, 14'h0348, 14'h0460, 14'h0578,
        14'h0690, 14'h08C0, 14'h0AF0, 14'h0D20, 14'h0F50, 14'h1180, 14'h15E0, 14'h1A40,
        14'h1EA0, 14'h22CA, 14'h2760, 14'h2BC0};
    localparam logic [7:0] RST_ADDR [6] = '{`TCIR_ADDR_GROUP_TIMING, `TCIR_ADDR_AUTO_RECAL,
        `TCIR_ADDR_MANUAL_TRIG, `TCIR_ADDR_TOUCH_IRQ, `TCIR_ADDR_GPIN_IRQ, `TCIR_ADDR_GROUP_TRIG};
    localparam logic [7:0] RST_VAL [6] = '{8'hD4, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00};

    logic clk_sys;
    logic resetn;
    logic regWrEn;
    logic regRdEn;
    logic [7:0] regAddr;
    logic [7:0] regWrData;
    logic [7:0] regRdData_r;
    tcir_sensor_mask_t sampleEn, autoRecalReq, touchRaw;
    tcir_sensor_mask_t touchReported_r, baseValid_r, calBusy_r;
    logic [1:0] slideSpeed;
    logic [6:0] touchStatus;
    logic [3:0] groupEventStatus;
    logic [7:0] gpinStatus;
    logic [13:0] pressLimitMs_r;
    logic [9:0] slideRepeatMs_r;
    logic alert_r;
    int failures;
    int totalChecks;
    int i;
    int n;
    int steps;
    logic [7:0] rdv;
    logic stuck;

    tcir_regs #(.CYC_PER_MS(CYC)) dut_u (.clk_sys(clk_sys), .resetn(resetn),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
        .regRdData_r(regRdData_r), .sampleEn(sampleEn), .autoRecalReq(autoRecalReq),
        .touchRaw(touchRaw), .slideSpeed(slideSpeed), .touchStatus(touchStatus),
        .groupEventStatus(groupEventStatus), .gpinStatus(gpinStatus),
        .touchReported_r(touchReported_r), .baseValid_r(baseValid_r), .calBusy_r(calBusy_r),
        .pressLimitMs_r(pressLimitMs_r), .slideRepeatMs_r(slideRepeatMs_r), .alert_r(alert_r));
    tcir_host_model host_u (.clk_sys(clk_sys), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regAddr(regAddr), .regWrData(regWrData), .regRdData_r(regRdData_r), .alert_r(alert_r));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cycles(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask

    // Bounded so a dead engine cannot hang the run
    task automatic waitBusy(input tcir_sensor_mask_t m);
        for (int k = 0; k < 20; k++) begin
            cycles(1);
            if ((calBusy_r & m) !== 14'h0000) break;
        end
    endtask

    task automatic waitIdle(output int k);
        for (k = 0; k < 3000; k++) begin
            cycles(1);
            if (calBusy_r === 14'h0000) break;
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", totalChecks, failures);
        if (failures == 0 && totalChecks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #200000;
        failures++;
        results();
    end

    initial begin
        failures = 0;
        totalChecks = 0;
        resetn = 1'b0;
        sampleEn = 14'h3FFF;
        autoRecalReq = 14'h0000;
        touchRaw = 14'h0000;
        slideSpeed = 2'h0;
        touchStatus = 7'h00;
        groupEventStatus = 4'h0;
        gpinStatus = 8'h00;
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b1;
        // ****************************************
        // Enables, readback and alert rows
        // ****************************************
        for (i = 0; i < 13; i++) begin
            host_u.wr(ROWS[i].addr, ROWS[i].wdata);
            host_u.rd(ROWS[i].addr, rdv);
            check(16'(rdv), 16'(ROWS[i].expRd));
            @(posedge clk_sys);
            touchStatus <= ROWS[i].tStat;
            groupEventStatus <= ROWS[i].gEv;
            gpinStatus <= ROWS[i].gp;
            cycles(3);
            check(16'(alert_r), 16'(ROWS[i].expAlert));
        end
        for (i = 0; i < 16; i++) begin
            @(posedge clk_sys);
            slideSpeed <= i[1:0];
            host_u.wr(`TCIR_ADDR_GROUP_TIMING, {i[3:0], i[3:0]});
            cycles(3);
            check(16'(pressLimitMs_r), 16'(PRESS_MS[i]));
            steps = (i + 1) >> i[1:0];
            if (steps == 0) steps = 1;
            check(16'(slideRepeatMs_r), 16'(steps * 16'h0023));
        end
        // ****************************************
        // Manual, failed and group recalibration
        // ****************************************
        host_u.wr(`TCIR_ADDR_MANUAL_TRIG, 8'h01);
        waitBusy(14'h0001);
        check(16'(calBusy_r), 16'h0001);
        check(16'(baseValid_r[0]), 16'h0000);
        host_u.rd(`TCIR_ADDR_MANUAL_TRIG, rdv);
        check(16'(rdv), 16'h0001);
        waitIdle(n);
        check(16'(n >= 2390 && n <= 2402), 16'h0001);
        cycles(2);
        host_u.rd(`TCIR_ADDR_MANUAL_TRIG, rdv);
        check(16'(rdv), 16'h0000);
        check(16'(baseValid_r[0]), 16'h0001);
        host_u.wr(`TCIR_ADDR_MANUAL_TRIG, 8'h02);
        waitBusy(14'h0002);
        @(posedge clk_sys);
        touchRaw <= 14'h0003;
        cycles(3);
        check(16'(touchReported_r), 16'h0001);
        @(posedge clk_sys);
        touchRaw <= 14'h0000;
        waitIdle(n);
        host_u.pollRetry(`TCIR_ADDR_MANUAL_TRIG, 8'h02, stuck);
        check(16'(stuck), 16'h0001);
        waitBusy(14'h0002);
        waitIdle(n);
        cycles(2);
        host_u.rd(`TCIR_ADDR_MANUAL_TRIG, rdv);
        check(16'(rdv), 16'h0000);
        host_u.wr(`TCIR_ADDR_MANUAL_TRIG, 8'h80);
        waitBusy(14'h3F80);
        check(16'(calBusy_r), 16'h3F80);
        host_u.rd(`TCIR_ADDR_GROUP_TRIG, rdv);
        check(16'(rdv), 16'h0000);
        waitIdle(n);
        cycles(2);
        host_u.rd(`TCIR_ADDR_MANUAL_TRIG, rdv);
        check(16'(rdv), 16'h0000);
        host_u.wr(`TCIR_ADDR_GROUP_TRIG, 8'h41);
        waitBusy(14'h3F80);
        check(16'(calBusy_r), 16'h2080);
        waitIdle(n);
        cycles(2);
        host_u.rd(`TCIR_ADDR_GROUP_TRIG, rdv);
        check(16'(rdv), 16'h0000);
        // ****************************************
        // Automatic recalibration gating
        // ****************************************
        host_u.wr(`TCIR_ADDR_AUTO_RECAL, 8'h7B);
        @(posedge clk_sys);
        sampleEn <= 14'h3FFD;
        autoRecalReq <= 14'h0106;
        cycles(20);
        check(16'(calBusy_r), 16'h0000);
        @(posedge clk_sys);
        sampleEn <= 14'h3FFF;
        waitBusy(14'h3FFF);
        check(16'(calBusy_r), 16'h0002);
        @(posedge clk_sys);
        autoRecalReq <= 14'h0000;
        waitIdle(n);
        host_u.wr(`TCIR_ADDR_AUTO_RECAL, 8'h80);
        @(posedge clk_sys);
        autoRecalReq <= 14'h0100;
        waitBusy(14'h3FFF);
        check(16'(calBusy_r), 16'h3F80);
        @(posedge clk_sys);
        autoRecalReq <= 14'h0000;
        slideSpeed <= 2'h0;
        waitIdle(n);
        // ****************************************
        // Long grouped press forces a recal
        // ****************************************
        host_u.wr(`TCIR_ADDR_GROUP_TIMING, 8'h04);
        @(posedge clk_sys);
        touchRaw <= 14'h0100;
        cycles(2200);
        check(16'(calBusy_r), 16'h0000);
        cycles(30);
        waitBusy(14'h3F80);
        check(16'(calBusy_r), 16'h3F80);
        check(16'(touchReported_r), 16'h0000);
        @(posedge clk_sys);
        touchRaw <= 14'h0000;
        waitIdle(n);
        check(16'(calBusy_r), 16'h0000);
        // ****************************************
        // Second reset in mid-run
        // ****************************************
        @(posedge clk_sys);
        resetn <= 1'b0;
        cycles(20);
        check(16'(alert_r), 16'h0000);
        @(posedge clk_sys);
        resetn <= 1'b1;
        cycles(2);
        check(16'(pressLimitMs_r), 16'h22CA);
        check(16'(slideRepeatMs_r), 16'h00AF);
        for (i = 0; i < 6; i++) begin
            host_u.rd(RST_ADDR[i], rdv);
            check(16'(rdv), 16'(RST_VAL[i]));
        end
        results();
    end
endmodule
